//--- rtl/cie_entry.sv
// Purpose: Interrupt entry for critical input, machine check, NMI and data storage.
// Assumes: Pipeline inputs and debug controls are on sys_clk_i; pins are asynchronous.
// Notes: Machine state may be rewritten by software through the write port.
`timescale 1ns/1ps
module cie_entry
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic crit_irq_n_i,
  input wire logic avec_n_i,
  input wire logic [9:0] voffset_i,
  input wire logic mchk_n_i,
  input wire logic nmi_n_i,
  input wire logic handler_fetch_err_i,
  input wire logic buffered_store_err_i,
  input wire logic dbus_err_i,
  input cie_pkg::cie_dsi_t dbus_err_info_i,
  input wire logic higher_pri_pending_i,
  input wire logic [31:0] next_pc_i,
  input wire logic [31:0] cur_pc_i,
  input wire logic [19:0] vector_prefix_i,
  input cie_pkg::cie_impl_control_t impl_control_i,
  input wire logic msr_wr_en_i,
  input wire logic [31:0] msr_wr_data_i,
  input wire logic [31:0] machine_check_syndrome_clr_i,
  input wire logic dbg_req_i,
  input wire logic dbg_exit_i,
  input wire logic dbg_reset_req_i,
  output logic [31:0] machine_state_reg_o,
  output logic [31:0] critical_save_pc_o,
  output logic [31:0] critical_save_status_o,
  output logic [31:0] save_restore_pc_o,
  output logic [31:0] save_restore_status_o,
  output logic [31:0] exception_syndrome_o,
  output logic [31:0] machine_check_syndrome_o,
  output logic [31:0] vector_o,
  output logic redirect_o,
  output cie_pkg::cie_kind_t entry_kind_o,
  output logic crit_ack_o,
  output logic halt_o,
  output logic chkstop_o,
  output logic wakeup_o,
  output logic debug_mode_o,
  output logic mchk_status_o,
  output logic reset_out_n_o
);

  // ==========================================================================
  // Pin synchronisation
  logic [13:0] pins_sync;
  logic crit_req;
  logic avec_n_s;
  logic [9:0] voffset_s;
  logic mchk_pin;
  logic nmi_level;
  logic nmi_prev;
  logic nmi_pend;

  cie_sync #(.W(14), .RST(cie_pkg::PIN_SYNC_RESET)) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .d_i({crit_irq_n_i, avec_n_i, mchk_n_i, nmi_n_i, voffset_i}),
    .q_o(pins_sync)
  );

  assign crit_req = ~pins_sync[13];
  assign avec_n_s = pins_sync[12];
  assign voffset_s = pins_sync[9:0];
  // Vectored requesters must already hold avec high and the offset stable.
  assign mchk_pin = ~pins_sync[11] & impl_control_i.mchk_pin_allow;
  assign nmi_level = ~pins_sync[10];

  // ==========================================================================
  // Decode of pending work
  cie_pkg::cie_state_t state;
  cie_pkg::cie_state_t next_state;
  cie_pkg::cie_kind_t next_kind;
  logic run;
  logic [31:0] machine_state_reg;
  logic [31:0] mchk_src;
  logic stop_evt;
  logic dsi_pend;
  cie_pkg::cie_dsi_t dsi_info;
  logic [31:0] next_vector;

  assign run = (state == cie_pkg::ST_RUN);

  always_comb
  begin
    mchk_src = 32'h0000_0000;
    mchk_src[cie_pkg::MACHINE_CHECK_SYNDROME_MCP] = mchk_pin;
    mchk_src[cie_pkg::MACHINE_CHECK_SYNDROME_EXCP] = handler_fetch_err_i;
    mchk_src[cie_pkg::MACHINE_CHECK_SYNDROME_WRERR] = buffered_store_err_i;
  end

  // The NMI bit is kept apart so that it can never cause a checkstop.
  assign stop_evt = run & ~machine_state_reg[cie_pkg::MSR_ME]
    & ((|mchk_src) | (dbus_err_i & ~machine_state_reg[cie_pkg::MSR_EE]));

  always_comb
  begin
    next_kind = cie_pkg::KIND_NONE;
    if (run && !higher_pri_pending_i && !stop_evt)
    begin
      if (nmi_pend || (machine_state_reg[cie_pkg::MSR_ME] && (|mchk_src)))
        next_kind = cie_pkg::KIND_MCHK;
      else if (dsi_pend)
        next_kind = cie_pkg::KIND_DSI;
      else if (crit_req && machine_state_reg[cie_pkg::MSR_CE])
        next_kind = cie_pkg::KIND_CRIT;
    end
  end

  cie_vector u_vector (
    .prefix_i(vector_prefix_i),
    .kind_i(next_kind),
    .avec_n_i(avec_n_s),
    .voffset_i(voffset_s),
    .vector_o(next_vector)
  );

  // ==========================================================================
  // Event capture; a new event in the taking cycle is kept.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      nmi_prev <= 1'b0;
      nmi_pend <= 1'b0;
    end
    else
    begin
      nmi_prev <= nmi_level;
      if (nmi_level && !nmi_prev)
        nmi_pend <= 1'b1;
      else if (next_kind == cie_pkg::KIND_MCHK)
        nmi_pend <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dsi_pend <= 1'b0;
      dsi_info <= '0;
    end
    else if (run && dbus_err_i && machine_state_reg[cie_pkg::MSR_EE])
    begin
      dsi_pend <= 1'b1;
      dsi_info <= dbus_err_info_i;
    end
    else if (next_kind == cie_pkg::KIND_DSI)
      dsi_pend <= 1'b0;
  end

  // ==========================================================================
  // Machine state update
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      machine_state_reg <= cie_pkg::MSR_RESET;
    else
    begin
      case (next_kind)
        cie_pkg::KIND_CRIT:
        begin
          machine_state_reg <= machine_state_reg & ~cie_pkg::MSR_CLR_CRIT;
          if (!impl_control_i.dbg_ext_enable || impl_control_i.critical_clears_dbg)
            machine_state_reg[cie_pkg::MSR_DE] <= 1'b0;
        end
        cie_pkg::KIND_MCHK:
        begin
          machine_state_reg <= machine_state_reg & ~cie_pkg::MSR_CLR_MCHK;
          if (!impl_control_i.dbg_ext_enable || impl_control_i.mchk_clears_dbg)
            machine_state_reg[cie_pkg::MSR_DE] <= 1'b0;
        end
        cie_pkg::KIND_DSI: machine_state_reg <= machine_state_reg & ~cie_pkg::MSR_CLR_DSI;
        default:
        begin
          if (msr_wr_en_i)
            machine_state_reg <= msr_wr_data_i & cie_pkg::MSR_IMPL_MASK;
        end
      endcase
    end
  end

  // ==========================================================================
  // Save and restore pairs
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      critical_save_pc_o <= 32'h0000_0000;
      critical_save_status_o <= 32'h0000_0000;
    end
    else if (next_kind == cie_pkg::KIND_CRIT)
    begin
      critical_save_pc_o <= next_pc_i;
      critical_save_status_o <= machine_state_reg;
    end
    else if (next_kind == cie_pkg::KIND_MCHK)
    begin
      critical_save_pc_o <= cur_pc_i;
      critical_save_status_o <= machine_state_reg;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      save_restore_pc_o <= 32'h0000_0000;
      save_restore_status_o <= 32'h0000_0000;
      exception_syndrome_o <= 32'h0000_0000;
    end
    else if (next_kind == cie_pkg::KIND_DSI)
    begin
      save_restore_pc_o <= dsi_info.pc;
      save_restore_status_o <= machine_state_reg;
      exception_syndrome_o <= 32'h0000_0000;
      exception_syndrome_o[cie_pkg::ESR_XTE] <= 1'b1;
      exception_syndrome_o[cie_pkg::ESR_ST] <= dsi_info.write;
      exception_syndrome_o[cie_pkg::ESR_VARLEN_INSN_FLAG] <= dsi_info.varlen;
    end
  end

  // ==========================================================================
  // Machine check syndrome; a new source wins over a software clear.
  logic [31:0] take_src;

  always_comb
  begin
    take_src = 32'h0000_0000;
    if (next_kind == cie_pkg::KIND_MCHK)
    begin
      take_src = mchk_src;
      take_src[cie_pkg::MACHINE_CHECK_SYNDROME_NMI] = nmi_pend;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      machine_check_syndrome_o <= 32'h0000_0000;
    else
      machine_check_syndrome_o <= (machine_check_syndrome_o & ~machine_check_syndrome_clr_i) | take_src;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      mchk_status_o <= 1'b0;
    else
      mchk_status_o <= |machine_check_syndrome_o;
  end

  // ==========================================================================
  // Redirect to the handler
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      vector_o <= 32'h0000_0000;
      redirect_o <= 1'b0;
      entry_kind_o <= cie_pkg::KIND_NONE;
      crit_ack_o <= 1'b0;
    end
    else
    begin
      redirect_o <= (next_kind != cie_pkg::KIND_NONE);
      entry_kind_o <= next_kind;
      crit_ack_o <= (next_kind == cie_pkg::KIND_CRIT);
      if (next_kind != cie_pkg::KIND_NONE)
        vector_o <= next_vector;
    end
  end

  // ==========================================================================
  // Checkstop and debug escape; only reset leaves the checkstop family.
  always_comb
  begin
    next_state = state;
    case (state)
      cie_pkg::ST_RUN: if (stop_evt) next_state = cie_pkg::ST_CHKSTOP;
      cie_pkg::ST_CHKSTOP: if (dbg_req_i) next_state = cie_pkg::ST_WAKE;
      cie_pkg::ST_WAKE: next_state = cie_pkg::ST_DEBUG;
      cie_pkg::ST_DEBUG: if (dbg_exit_i) next_state = cie_pkg::ST_CHKSTOP;
      default: next_state = cie_pkg::ST_CHKSTOP;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state <= cie_pkg::ST_RUN;
    else
      state <= next_state;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reset_out_n_o <= 1'b1;
    else
      reset_out_n_o <= ~dbg_reset_req_i;
  end

  assign machine_state_reg_o = machine_state_reg;
  assign halt_o = ~run;
  assign chkstop_o = (state == cie_pkg::ST_CHKSTOP) | (state == cie_pkg::ST_WAKE);
  assign wakeup_o = (state == cie_pkg::ST_WAKE);
  assign debug_mode_o = (state == cie_pkg::ST_DEBUG);

  // ==========================================================================
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_wake_entry;
    chkstop_o && dbg_req_i && !wakeup_o;
  endsequence

  sequence s_debug_walk;
    wakeup_o && chkstop_o ##1 debug_mode_o && !chkstop_o;
  endsequence

  chk_crit_enable: assert property (crit_ack_o |-> $past(machine_state_reg[cie_pkg::MSR_CE]) && !machine_state_reg[cie_pkg::MSR_CE])
    else $error("critical entry without enable");
  chk_crit_save: assert property (crit_ack_o |->
    critical_save_pc_o == $past(next_pc_i) && critical_save_status_o == $past(machine_state_reg))
    else $error("critical save pair wrong");
  chk_crit_keep: assert property (crit_ack_o |->
    machine_state_reg[cie_pkg::MSR_ME] == $past(machine_state_reg[cie_pkg::MSR_ME]) && !machine_state_reg[cie_pkg::MSR_RI]
    && !machine_state_reg[cie_pkg::MSR_EE])
    else $error("critical entry state bits wrong");
  chk_crit_vector: assert property (crit_ack_o && $past(!avec_n_s) |->
    vector_o == {vector_prefix_i, cie_pkg::OFS_CRIT})
    else $error("autovectored critical address wrong");
  chk_mchk_entry: assert property (entry_kind_o == cie_pkg::KIND_MCHK |->
    vector_o[11:0] == cie_pkg::OFS_MCHK && !machine_state_reg[cie_pkg::MSR_ME] && !machine_state_reg[cie_pkg::MSR_RI])
    else $error("machine check entry wrong");
  chk_stop_enter: assert property (stop_evt |=> chkstop_o && halt_o ##1 halt_o)
    else $error("checkstop not entered");
  chk_stop_hold: assert property (chkstop_o && !dbg_req_i |=> chkstop_o)
    else $error("checkstop left without debug");
  chk_debug_walk: assert property (s_wake_entry |=> s_debug_walk)
    else $error("debug escape sequence wrong");
  chk_dsi_keep: assert property (entry_kind_o == cie_pkg::KIND_DSI |->
    vector_o[11:0] == cie_pkg::OFS_DSI && exception_syndrome_o[cie_pkg::ESR_XTE]
    && machine_state_reg[cie_pkg::MSR_CE] == $past(machine_state_reg[cie_pkg::MSR_CE])
    && machine_state_reg[cie_pkg::MSR_RI] == $past(machine_state_reg[cie_pkg::MSR_RI]))
    else $error("data storage entry wrong");
  chk_mchk_status: assert property (machine_check_syndrome_o != 32'h0000_0000 |=> mchk_status_o)
    else $error("machine check status not raised");

endmodule : cie_entry

//--- rtl/cie_pkg.sv
// Purpose: Shared constants and types for the core interrupt entry block.
// Assumes: Machine state and syndrome words use bit 0 as the least significant bit.
// Notes: Bit positions are the documented big-endian positions mirrored (31 - n).
// ============================================================================
// Overview of operation
// - Critical input taken only with critical enable set and nothing higher pending.
// - Critical entry saves next instruction address and machine state in critical pair.
// - Critical vector is prefix plus 0x000, or external offset with two zeros.
// - Critical entry clears debug enable unless extension on and control bit clear.
// - Recoverable bit cleared on critical and machine check entries.
// - Machine check taken when enabled and any source seen, vector offset 0x010.
// - Machine check entry saves address and state, clears enable, records sources.
// - Machine check entry clears debug enable per extension state and control bit.
// - Machine check source with enable clear enters checkstop instead.
// - External machine check pin ignored when the pin allow control masks it.
// - Handler fetch, buffered store or precise errors checkstop when enables clear.
// - Checkstop suspends processing until reset; status output high except while in debug.
// - Debug request in checkstop wakes, enters debug, then returns to checkstop.
// - Debug control can request reset out, even while checkstopped.
// - Non-maskable input ignores machine check enable, never checkstops, overwrites pair.
// - Bus error on load or store with external enable set takes data storage entry.
// - Data storage entry saves address and state, sets syndrome flags, vector 0x020.
// - Data storage entry clears listed state bits, keeps critical, check, debug, RI.
// - Any machine check syndrome bit set drives the machine check status output.
package cie_pkg;

  // ==========================================================================
  // Machine state bit positions
  localparam int MSR_USER_LOCK_ALLOW = 26;
  localparam int MSR_WE = 18;
  localparam int MSR_CE = 17;
  localparam int MSR_EE = 15;
  localparam int MSR_PR = 14;
  localparam int MSR_FP = 13;
  localparam int MSR_ME = 12;
  localparam int MSR_FE0 = 11;
  localparam int MSR_DE = 9;
  localparam int MSR_FE1 = 8;
  localparam int MSR_IS = 5;
  localparam int MSR_DS = 4;
  localparam int MSR_RI = 1;
  localparam logic [31:0] MSR_RESET = 32'h0000_0000;
  localparam logic [31:0] MSR_IMPL_MASK = 32'h0406_FB32;
  // Bits cleared on entry, one mask for each kind; debug enable is decided separately per kind.
  localparam logic [31:0] MSR_CLR_DSI = 32'h0404_E930;
  localparam logic [31:0] MSR_CLR_CRIT = 32'h0406_E932;
  localparam logic [31:0] MSR_CLR_MCHK = 32'h0406_F932;

  // ==========================================================================
  // Syndrome bit positions
  localparam int MACHINE_CHECK_SYNDROME_MCP = 31;
  localparam int MACHINE_CHECK_SYNDROME_EXCP = 27;
  localparam int MACHINE_CHECK_SYNDROME_NMI = 20;
  localparam int MACHINE_CHECK_SYNDROME_WRERR = 2;
  localparam int ESR_XTE = 0;
  localparam int ESR_ST = 23;
  localparam int ESR_VARLEN_INSN_FLAG = 5;

  // ==========================================================================
  // Vector offsets and pin synchroniser reset value
  localparam logic [11:0] OFS_CRIT = 12'h000;
  localparam logic [11:0] OFS_MCHK = 12'h010;
  localparam logic [11:0] OFS_DSI = 12'h020;
  localparam logic [1:0] OFS_PAD = 2'h0;
  localparam logic [13:0] PIN_SYNC_RESET = 14'h3C00;

  typedef enum logic [1:0] {
    KIND_NONE = 2'b00,
    KIND_CRIT = 2'b01,
    KIND_MCHK = 2'b10,
    KIND_DSI = 2'b11
  } cie_kind_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_CHKSTOP = 2'b01,
    ST_WAKE = 2'b10,
    ST_DEBUG = 2'b11
  } cie_state_t;

  typedef struct packed {
    logic dbg_ext_enable;
    logic critical_clears_dbg;
    logic mchk_clears_dbg;
    logic mchk_pin_allow;
  } cie_impl_control_t;

  typedef struct packed {
    logic [31:0] pc;
    logic write;
    logic varlen;
  } cie_dsi_t;

endpackage : cie_pkg

//--- rtl/cie_sync.sv
// Purpose: Two-stage synchroniser for asynchronous input pins.
// Assumes: Each bit is an independent level.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module cie_sync
#(
  parameter int W = 14,
  parameter logic [W-1:0] RST = '0
)
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta;

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta <= RST;
      q_o <= RST;
    end
    else
    begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule : cie_sync

//--- rtl/cie_vector.sv
// Purpose: Forms the handler address for the entry kind being taken.
// Assumes: Offset select inputs are already synchronised.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module cie_vector
(
  input wire logic [19:0] prefix_i,
  input cie_pkg::cie_kind_t kind_i,
  input wire logic avec_n_i,
  input wire logic [9:0] voffset_i,
  output logic [31:0] vector_o
);

  always_comb
  begin
    case (kind_i)
      cie_pkg::KIND_CRIT:
      begin
        if (!avec_n_i)
          vector_o = {prefix_i, cie_pkg::OFS_CRIT};
        else
          vector_o = {prefix_i, voffset_i, cie_pkg::OFS_PAD};
      end
      cie_pkg::KIND_MCHK: vector_o = {prefix_i, cie_pkg::OFS_MCHK};
      cie_pkg::KIND_DSI: vector_o = {prefix_i, cie_pkg::OFS_DSI};
      default: vector_o = {prefix_i, cie_pkg::OFS_CRIT};
    endcase
  end

endmodule : cie_vector

//--- verification/cie_far_model.sv
// Purpose: Far-side model of the interrupt controller feeding the critical request pin.
// Assumes: The acknowledge from the core is a one-cycle pulse.
// Notes: Idle offset lines toggle each cycle, so a stale value can never pass for a fresh one.
`timescale 1ns/1ps
module cie_far_model
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic go_i,
  input wire logic vec_i,
  input wire logic slow_i,
  input wire logic [9:0] voff_i,
  input wire logic crit_ack_i,
  output logic crit_irq_n_o,
  output logic avec_n_o,
  output logic [9:0] voffset_o
);
  logic [1:0] lag;
  logic armed;
  logic req;

  // ==========
  // Request level, held until acknowledged
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      lag <= 2'h0;
      armed <= 1'b0;
      req <= 1'b0;
    end
    else if (go_i)
    begin
      lag <= slow_i ? 2'h3 : 2'h0;
      armed <= 1'b1;
    end
    else if (armed && lag != 2'h0)
    begin
      lag <= lag - 2'h1;
    end
    else if (armed)
    begin
      armed <= 1'b0;
      req <= 1'b1;
    end
    else if (crit_ack_i)
    begin
      req <= 1'b0;
    end
  end

  assign crit_irq_n_o = !req;

  // ==========
  // Vector select and offset, presented on go_i ahead of the request and held with it
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      avec_n_o <= 1'b1;
      voffset_o <= 10'h155;
    end
    else if (go_i)
    begin
      avec_n_o <= vec_i;
      voffset_o <= voff_i;
    end
    else if (!req && !armed)
    begin
      avec_n_o <= !avec_n_o;
      voffset_o <= ~voffset_o;
    end
  end
endmodule : cie_far_model

//--- verification/tb.sv
// Purpose: Self-checking bench for the interrupt entry block.
// Assumes: Every entry answers within twelve cycles of its cause.
// Notes: Checkstop is left only through reset, so each checkstop case starts with one.
`timescale 1ns/1ps
module tb;
  typedef struct {
    logic [2:0] t;
    logic [31:0] state;
    logic [3:0] ctl;
    logic [9:0] voff;
    logic [11:0] ofs;
  } cie_row_t;

  // ==========
  // Signals
  logic sys_clk_i, rst_n_i, mchk_n_i, nmi_n_i, handler_fetch_err_i, buffered_store_err_i;
  logic dbus_err_i, higher_pri_pending_i, msr_wr_en_i, dbg_req_i, dbg_exit_i, dbg_reset_req_i;
  logic go_i, vec_i, slow_i;
  logic [9:0] voff_i;
  logic [31:0] msr_wr_data_i, machine_check_syndrome_clr_i, next_pc_i, cur_pc_i, synd;
  logic [19:0] vector_prefix_i;
  cie_pkg::cie_dsi_t dbus_err_info_i;
  cie_pkg::cie_impl_control_t impl_control_i;
  wire logic crit_irq_n_i, avec_n_i;
  wire logic [9:0] voffset_i;
  logic [31:0] machine_state_reg_o, critical_save_pc_o, critical_save_status_o, save_restore_pc_o;
  logic [31:0] save_restore_status_o, exception_syndrome_o, machine_check_syndrome_o, vector_o;
  logic redirect_o, crit_ack_o, halt_o, chkstop_o, wakeup_o, debug_mode_o, mchk_status_o;
  logic reset_out_n_o;
  cie_pkg::cie_kind_t entry_kind_o;
  int mismatches, n_checks;
  localparam logic [31:0] DSI_SYND = (32'h1 << cie_pkg::ESR_XTE) | (32'h1 << cie_pkg::ESR_ST)
    | (32'h1 << cie_pkg::ESR_VARLEN_INSN_FLAG);
  int gone[9] = '{cie_pkg::MSR_USER_LOCK_ALLOW, cie_pkg::MSR_WE, cie_pkg::MSR_EE, cie_pkg::MSR_PR,
    cie_pkg::MSR_FP, cie_pkg::MSR_FE0, cie_pkg::MSR_FE1, cie_pkg::MSR_IS, cie_pkg::MSR_DS};
  // Cause codes: 0 pin, 1 handler fetch, 3 load/store error, 4 NMI, 5 autovector, 6 vectored.
  cie_row_t rows[8] = '{
    '{3'h5, 32'h0406_FB32, 4'h1, 10'h000, 12'h000},
    '{3'h6, 32'h0406_FB32, 4'h9, 10'h2A5, 12'hA94},
    '{3'h5, 32'h0002_0200, 4'hD, 10'h000, 12'h000},
    '{3'h0, 32'h0406_FB32, 4'h9, 10'h000, 12'h010},
    '{3'h4, 32'h0000_0200, 4'hA, 10'h000, 12'h010},
    '{3'h1, 32'h0000_1000, 4'h0, 10'h000, 12'h010},
    '{3'h3, 32'h0406_FB32, 4'h1, 10'h000, 12'h020},
    '{3'h6, 32'h0406_FB32, 4'h9, 10'h3FF, 12'hFFC}};

  cie_entry cie_entry_inst (.sys_clk_i, .rst_n_i, .crit_irq_n_i, .avec_n_i, .voffset_i,
    .mchk_n_i, .nmi_n_i, .handler_fetch_err_i, .buffered_store_err_i, .dbus_err_i,
    .dbus_err_info_i, .higher_pri_pending_i, .next_pc_i, .cur_pc_i, .vector_prefix_i,
    .impl_control_i, .msr_wr_en_i, .msr_wr_data_i, .machine_check_syndrome_clr_i, .dbg_req_i, .dbg_exit_i,
    .dbg_reset_req_i, .machine_state_reg_o, .critical_save_pc_o, .critical_save_status_o,
    .save_restore_pc_o, .save_restore_status_o, .exception_syndrome_o,
    .machine_check_syndrome_o, .vector_o, .redirect_o, .entry_kind_o, .crit_ack_o, .halt_o,
    .chkstop_o, .wakeup_o, .debug_mode_o, .mchk_status_o, .reset_out_n_o);

  cie_far_model cie_far_model_inst (.sys_clk_i, .rst_n_i, .go_i, .vec_i, .slow_i, .voff_i,
    .crit_ack_i(crit_ack_o), .crit_irq_n_o(crit_irq_n_i), .avec_n_o(avec_n_i),
    .voffset_o(voffset_i));

  always #5 sys_clk_i = ~sys_clk_i;

  // ==========
  // Tasks
  task automatic step;
    @(posedge sys_clk_i);
    #1;
  endtask : step

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_checks++;
    if (got !== want)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h want=%h", $time, got, want);
    end
  endtask : chk

  task automatic wrap_up;
    if (mismatches == 0 && n_checks > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic do_reset;
    rst_n_i = 1'b0;
    repeat (10) step();
    rst_n_i = 1'b1;
    step();
  endtask : do_reset

  task automatic load(input logic [31:0] v, input logic [3:0] c);
    impl_control_i = c;
    msr_wr_en_i = 1'b1;
    msr_wr_data_i = v;
    step();
    msr_wr_en_i = 1'b0;
  endtask : load

  // One cycle of the chosen cause; pins are released again so a level cannot retrigger.
  task automatic hit(input int k);
    mchk_n_i = (k != 0);
    handler_fetch_err_i = (k == 1);
    buffered_store_err_i = (k == 2);
    dbus_err_i = (k == 3);
    nmi_n_i = (k != 4);
    go_i = (k >= 5);
    vec_i = (k == 6);
    slow_i = (k == 6);
    step();
    {mchk_n_i, nmi_n_i} = 2'b11;
    {handler_fetch_err_i, buffered_store_err_i, dbus_err_i, go_i} = 4'h0;
  endtask : hit

  task automatic wait_redirect;
    int n;
    n = 0;
    while (redirect_o !== 1'b1 && n < 12)
    begin
      step();
      n++;
    end
    chk(n < 12, 1'b1);
  endtask : wait_redirect

  task automatic quiet(input int n);
    repeat (n)
    begin
      step();
      chk({redirect_o, chkstop_o}, 2'b00);
    end
  endtask : quiet

  function automatic logic [31:0] after(input cie_pkg::cie_kind_t k, input logic [31:0] v,
      input logic [3:0] c);
    logic [31:0] r;
    r = v;
    foreach (gone[i])
    begin
      r[gone[i]] = 1'b0;
    end
    if (k != cie_pkg::KIND_DSI)
    begin
      r[cie_pkg::MSR_CE] = 1'b0;
      r[cie_pkg::MSR_RI] = 1'b0;
      if (!c[3] || c[k == cie_pkg::KIND_CRIT ? 2 : 1])
      begin
        r[cie_pkg::MSR_DE] = 1'b0;
      end
    end
    if (k == cie_pkg::KIND_MCHK)
    begin
      r[cie_pkg::MSR_ME] = 1'b0;
    end
    return r;
  endfunction : after

  task automatic run_row(input cie_row_t r);
    cie_pkg::cie_kind_t k;
    logic [31:0] mc;
    k = r.t >= 3'h5 ? cie_pkg::KIND_CRIT : (r.t == 3'h3 ? cie_pkg::KIND_DSI : cie_pkg::KIND_MCHK);
    mc = r.t == 3'h0 ? 32'h1 << cie_pkg::MACHINE_CHECK_SYNDROME_MCP : r.t == 3'h1 ? 32'h1 << cie_pkg::MACHINE_CHECK_SYNDROME_EXCP
      : r.t == 3'h4 ? 32'h1 << cie_pkg::MACHINE_CHECK_SYNDROME_NMI : 32'h0;
    load(r.state, r.ctl);
    voff_i = r.voff;
    hit(r.t);
    wait_redirect();
    chk(entry_kind_o, k);
    chk(vector_o, {vector_prefix_i, r.ofs});
    chk(crit_ack_o, k == cie_pkg::KIND_CRIT);
    chk(machine_state_reg_o, after(k, r.state, r.ctl));
    chk(machine_check_syndrome_o, mc);
    chk(chkstop_o, 1'b0);
    if (k != cie_pkg::KIND_DSI)
    begin
      chk(critical_save_status_o, r.state);
      chk(critical_save_pc_o, k == cie_pkg::KIND_CRIT ? next_pc_i : cur_pc_i);
      chk(exception_syndrome_o, synd);
    end
    else
    begin
      chk(save_restore_pc_o, dbus_err_info_i.pc);
      chk(save_restore_status_o, r.state);
      chk(exception_syndrome_o, DSI_SYND);
      synd = DSI_SYND;
    end
    step();
    chk(mchk_status_o, mc != 32'h0);
    machine_check_syndrome_clr_i = 32'hFFFF_FFFF;
    step();
    machine_check_syndrome_clr_i = 32'h0;
    repeat (4) step();
  endtask : run_row

  // ==========
  // Sequence
  initial
  begin
    sys_clk_i = 1'b0;
    rst_n_i = 1'b0;
    {mchk_n_i, nmi_n_i} = 2'b11;
    {handler_fetch_err_i, buffered_store_err_i, dbus_err_i, higher_pri_pending_i} = 4'h0;
    {msr_wr_en_i, dbg_req_i, dbg_exit_i, dbg_reset_req_i, go_i, vec_i, slow_i} = 7'h00;
    voff_i = 10'h000;
    msr_wr_data_i = 32'h0;
    machine_check_syndrome_clr_i = 32'h0;
    next_pc_i = 32'h0000_1234;
    cur_pc_i = 32'h0000_1230;
    vector_prefix_i = 20'hABCDE;
    dbus_err_info_i = '{pc: 32'h0000_8004, write: 1'b1, varlen: 1'b1};
    impl_control_i = 4'h1;
    synd = 32'h0;
    mismatches = 0;
    n_checks = 0;
    do_reset();
    chk(machine_state_reg_o, cie_pkg::MSR_RESET);
    chk({reset_out_n_o, chkstop_o}, 2'b10);
    foreach (rows[i])
    begin
      run_row(rows[i]);
    end
    load(32'h0, 4'h1);
    voff_i = 10'h000;
    hit(5);
    quiet(8);
    higher_pri_pending_i = 1'b1;
    load(32'h0002_0000, 4'h1);
    quiet(8);
    higher_pri_pending_i = 1'b0;
    wait_redirect();
    chk(crit_ack_o, 1'b1);
    repeat (2) step();
    chk(crit_irq_n_i, 1'b1);
    load(32'h0000_1000, 4'h0);
    hit(0);
    quiet(8);
    hit(3);
    quiet(8);
    for (int k = 0; k < 4; k++)
    begin
      do_reset();
      impl_control_i = 4'h1;
      hit(k);
      repeat (3) step();
      chk({chkstop_o, halt_o, redirect_o}, 3'b110);
    end
    dbg_reset_req_i = 1'b1;
    step();
    chk(reset_out_n_o, 1'b0);
    dbg_reset_req_i = 1'b0;
    dbg_req_i = 1'b1;
    step();
    chk(reset_out_n_o, 1'b1);
    chk({wakeup_o, chkstop_o, debug_mode_o}, 3'b110);
    step();
    dbg_req_i = 1'b0;
    chk({wakeup_o, chkstop_o, debug_mode_o}, 3'b001);
    dbg_exit_i = 1'b1;
    step();
    dbg_exit_i = 1'b0;
    chk({chkstop_o, debug_mode_o}, 2'b10);
    do_reset();
    chk(chkstop_o, 1'b0);
    wrap_up();
  end

  // A hang ends the run the same way, counted as a mismatch.
  initial
  begin
    #100000;
    mismatches++;
    wrap_up();
  end
endmodule : tb
